// *** hdl/dtd_defines.svh ***
`ifndef DTD_DEFINES_SVH
`define DTD_DEFINES_SVH

// ****************************************************************
// Opcode groups (top nibble)
// ****************************************************************
`define DTD_TOP_IDXST   4'h0
`define DTD_TOP_LDISPST 4'h1
`define DTD_TOP_STIND   4'h2
`define DTD_TOP_LDISPLD 4'h5
`define DTD_TOP_LDIND   4'h6
`define DTD_TOP_R0DISP  4'h8
`define DTD_TOP_PCW     4'h9
`define DTD_TOP_PCL     4'hD
`define DTD_TOP_IMM     4'hE

// ****************************************************************
// Low nibble patterns and sub-codes
// ****************************************************************
`define DTD_LO_B        4'h0
`define DTD_LO_W        4'h1
`define DTD_LO_L        4'h2
`define DTD_LO_RR       4'h3
`define DTD_LO_BAU      4'h4
`define DTD_LO_WAU      4'h5
`define DTD_LO_LAU      4'h6
`define DTD_SUB_STB     4'h0
`define DTD_SUB_STW     4'h1
`define DTD_SUB_LDB     4'h4
`define DTD_SUB_LDW     4'h5

// ****************************************************************
// Sizes, register indices and timing
// ****************************************************************
`define DTD_SZ_B        2'h0
`define DTD_SZ_W        2'h1
`define DTD_SZ_L        2'h2
`define DTD_REG_ZERO    4'h0
`define DTD_BASE_CYCLES 4'h1

// ****************************************************************
// One-hot state codes
// ****************************************************************
`define DTD_ST_IDLE     6'h01
`define DTD_ST_STALL    6'h02
`define DTD_ST_READ     6'h04
`define DTD_ST_EXEC     6'h08
`define DTD_ST_MEM      6'h10
`define DTD_ST_WB       6'h20

`endif

// *** hdl/dtd_pkg.sv ***
`include "dtd_defines.svh"

package dtd_pkg;

    typedef enum logic [5:0] {
        ST_IDLE  = `DTD_ST_IDLE,
        ST_STALL = `DTD_ST_STALL,
        ST_READ  = `DTD_ST_READ,
        ST_EXEC  = `DTD_ST_EXEC,
        ST_MEM   = `DTD_ST_MEM,
        ST_WB    = `DTD_ST_WB
    } dtd_state_t;

    // Address base: port A (bits 7:4), port B (bits 11:8), PC, R0 + B
    typedef enum logic [1:0] {
        BASE_A, BASE_B, BASE_PC, BASE_CB
    } dtd_base_t;

    typedef enum logic [1:0] {
        UPD_NONE, UPD_PRE, UPD_POST
    } dtd_upd_t;

    typedef struct packed {
        logic      ok;
        logic      ld;
        logic      st;
        logic      imm;
        logic      rr;
        logic      dat_c;
        logic [1:0] sz;
        dtd_base_t base;
        logic [7:0] disp;
        logic [3:0] dst;
        dtd_upd_t  upd;
    } dtd_dec_t;

endpackage : dtd_pkg

// *** hdl/dtd_rf_if.sv ***
`timescale 1ns/1ps

// Register file ports: A reads bits 7:4, B reads bits 11:8, C is R0
interface dtd_rf_if;
    logic [3:0]  ra_idx;
    logic [3:0]  rb_idx;
    logic [31:0] ra_data;
    logic [31:0] rb_data;
    logic [31:0] rc_data;
    logic        we;
    logic [3:0]  widx;
    logic [31:0] wdata;

    modport ctrl (output ra_idx, rb_idx, we, widx, wdata,
                  input  ra_data, rb_data, rc_data);
    modport store (input  ra_idx, rb_idx, we, widx, wdata,
                   output ra_data, rb_data, rc_data);
endinterface : dtd_rf_if

// *** hdl/dtd_regfile.sv ***
`timescale 1ns/1ps

`include "dtd_defines.svh"

module dtd_regfile
    import dtd_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    dtd_rf_if.store   rf
);

    logic [31:0] regs_q [16];
    logic [31:0] ra_q;
    logic [31:0] rb_q;
    logic [31:0] rc_q;

    // ************************************************************
    // Storage, one write port
    // ************************************************************
    for (genvar i = 0; i < 16; i++) begin : g_ent
        logic [31:0] ent_d;
        always_comb begin
            ent_d = regs_q[i];
            if (rf.we && rf.widx == 4'(i)) begin
                ent_d = rf.wdata;
            end
        end
        always_ff @(posedge clock) begin
            if (!rst_n) regs_q[i] <= 32'h0;
            else        regs_q[i] <= ent_d;
        end
    end

    // ************************************************************
    // Registered reads
    // ************************************************************
    // Read data lands one cycle after the index, so the
    // controller spends one state waiting for it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ra_q <= 32'h0;
            rb_q <= 32'h0;
            rc_q <= 32'h0;
        end else begin
            ra_q <= regs_q[rf.ra_idx];
            rb_q <= regs_q[rf.rb_idx];
            rc_q <= regs_q[`DTD_REG_ZERO];
        end
    end

    assign rf.ra_data = ra_q;
    assign rf.rb_data = rb_q;
    assign rf.rc_data = rc_q;

endmodule : dtd_regfile

// *** hdl/dtd_decode.sv ***
`timescale 1ns/1ps

`include "dtd_defines.svh"

// Overview of operation
// RL1: Register numbers come from 4-bit binary fields
// RL2: Displacement scaled by access size before adding
// RL3: Immediate load sign-extends 8 bits into destination
// RL4: PC-relative loads, word extended, longword not
// RL5: Indirect loads extend byte and word only
// RL6: Pre-decrement store lowers base, writes there
// RL7: Post-increment load then advances source by size
// RL8: Byte/word displacement stores write register zero
// RL9: Longword displacement store uses four-times scaling
// RL10: Byte/word displacement loads target register zero
// RL11: Longword displacement load, no extension
// RL12: Byte indexed store at R0 plus base
// RL13: At least one cycle per instruction
// RL14: Stall when next instruction uses loaded register (code checks only bits 7:4 and 11:8, not R0 read through port C)
// RL15: No privilege needed, test flag untouched
// RL16: Register move copies full 32 bits
// RL17: Indirect stores leave both registers unchanged
// RL18: Other encodings passed on, no memory access

module dtd_decode
    import dtd_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        insn_valid,
    input  wire logic [15:0] insn,
    input  wire logic [31:0] pc,
    output logic             insn_ready_q,
    output logic             mem_req_q,
    output logic             mem_we_q,
    output logic [1:0]       mem_size_q,
    output logic [31:0]      mem_addr_q,
    output logic [31:0]      mem_wdata_q,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    output logic             wb_en_q,
    output logic [3:0]       wb_idx_q,
    output logic [31:0]      wb_data_q,
    output logic             pass_q,
    output logic [15:0]      pass_insn_q,
    output logic             done_q,
    output logic [3:0]       base_cycles_q,
    output logic             priv_req_q,
    output logic             tbit_we_q
);

    dtd_rf_if rf ();

    dtd_regfile u_rf (
        .clock (clock),
        .rst_n (rst_n),
        .rf    (rf)
    );

    // ************************************************************
    // Decode
    // ************************************************************
    function automatic dtd_dec_t decode(input logic [15:0] c);
        dtd_dec_t d;
        d = '0;
        d.dst  = c[11:8];                              // [RL1]
        d.base = BASE_A;
        d.upd  = UPD_NONE;
        case (c[15:12])
            `DTD_TOP_IMM: begin
                d.ok  = 1'b1;
                d.imm = 1'b1;
            end
            `DTD_TOP_PCW, `DTD_TOP_PCL: begin
                d.ok   = 1'b1;
                d.ld   = 1'b1;
                d.base = BASE_PC;
                d.disp = c[7:0];
                d.sz   = (c[15:12] == `DTD_TOP_PCW) ? `DTD_SZ_W
                                                    : `DTD_SZ_L; // [RL4]
            end
            `DTD_TOP_LDIND: begin
                if (c[3:0] == `DTD_LO_RR) begin
                    d.ok = 1'b1;
                    d.rr = 1'b1;                       // [RL16]
                end else if (c[3:0] <= `DTD_LO_L) begin
                    d.ok = 1'b1;
                    d.ld = 1'b1;                       // [RL5]
                    d.sz = c[1:0];
                end else if (c[3:0] >= `DTD_LO_BAU &&
                             c[3:0] <= `DTD_LO_LAU) begin
                    d.ok  = 1'b1;
                    d.ld  = 1'b1;
                    // Low two bits give the size directly
                    d.sz  = c[1:0];
                    d.upd = UPD_POST;                  // [RL7]
                end
            end
            `DTD_TOP_STIND: begin
                d.base = BASE_B;
                if (c[3:0] <= `DTD_LO_L) begin
                    d.ok = 1'b1;
                    d.st = 1'b1;                       // [RL17]
                    d.sz = c[1:0];
                end else if (c[3:0] >= `DTD_LO_BAU &&
                             c[3:0] <= `DTD_LO_LAU) begin
                    d.ok  = 1'b1;
                    d.st  = 1'b1;
                    d.sz  = c[1:0];
                    d.upd = UPD_PRE;                   // [RL6]
                end
            end
            `DTD_TOP_LDISPST: begin
                d.ok   = 1'b1;
                d.st   = 1'b1;
                d.base = BASE_B;
                d.sz   = `DTD_SZ_L;                    // [RL9]
                d.disp = {4'h0, c[3:0]};
            end
            `DTD_TOP_LDISPLD: begin
                d.ok   = 1'b1;
                d.ld   = 1'b1;
                d.sz   = `DTD_SZ_L;                    // [RL11]
                d.disp = {4'h0, c[3:0]};
            end
            `DTD_TOP_R0DISP: begin
                d.disp  = {4'h0, c[3:0]};
                d.sz    = c[9:8];
                d.dat_c = 1'b1;                        // [RL8]
                d.dst   = `DTD_REG_ZERO;               // [RL10]
                case (c[11:8])
                    `DTD_SUB_STB, `DTD_SUB_STW: begin
                        d.ok = 1'b1;
                        d.st = 1'b1;
                    end
                    `DTD_SUB_LDB, `DTD_SUB_LDW: begin
                        d.ok = 1'b1;
                        d.ld = 1'b1;
                    end
                    default: d.ok = 1'b0;
                endcase
            end
            `DTD_TOP_IDXST: begin
                if (c[3:0] == `DTD_LO_BAU) begin
                    d.ok   = 1'b1;
                    d.st   = 1'b1;
                    d.sz   = `DTD_SZ_B;
                    d.base = BASE_CB;                  // [RL12]
                end
            end
            default: d.ok = 1'b0;                      // [RL18]
        endcase
        return d;
    endfunction : decode

    // Byte/word load data is sign-extended, longword kept
    function automatic logic [31:0] sext(input logic [31:0] v,
                                         input logic [1:0]  sz);
        case (sz)
            `DTD_SZ_B: sext = {{24{v[7]}}, v[7:0]};
            `DTD_SZ_W: sext = {{16{v[15]}}, v[15:0]};
            default:   sext = v;
        endcase
    endfunction : sext

    // ************************************************************
    // Control state
    // ************************************************************
    dtd_state_t  state_q, state_d;
    logic [15:0] insn_q, insn_d;
    logic [31:0] pc_q, pc_d;
    logic        upd_en_q, upd_en_d;
    logic [3:0]  upd_idx_q, upd_idx_d;
    logic [31:0] upd_data_q, upd_data_d;
    logic        ld_pend_q, ld_pend_d;
    logic [3:0]  ld_idx_q, ld_idx_d;
    logic        ready_d, req_d, we_d, wb_en_d, pass_d, done_d;
    logic [1:0]  size_d;
    logic [31:0] addr_d, wdata_d, wb_data_d;
    logic [3:0]  wb_idx_d;
    logic [15:0] pass_insn_d;
    dtd_dec_t    dec_in, dec;
    logic        hazard;
    logic [31:0] base, step;

    assign dec_in = decode(insn);
    assign dec    = decode(insn_q);
    // Stall when bits 7:4 or 11:8 name the last loaded register
    assign hazard = ld_pend_q && (insn[7:4] == ld_idx_q ||
                                  insn[11:8] == ld_idx_q);
    assign step   = 32'h1 << dec.sz;                   // [RL2]

    // Register file is driven from held fields and write flops
    assign rf.ra_idx = insn_q[7:4];                    // [RL1]
    assign rf.rb_idx = insn_q[11:8];                   // [RL1]
    assign rf.we     = wb_en_q;
    assign rf.widx   = wb_idx_q;
    assign rf.wdata  = wb_data_q;

    // Base selection for address formation
    always_comb begin
        case (dec.base)
            BASE_A:  base = rf.ra_data;
            BASE_B:  base = rf.rb_data;
            BASE_PC: base = pc_q;
            default: base = rf.rc_data + rf.rb_data;   // [RL12]
        endcase
    end

    // Next-state logic for the whole sequencer
    always_comb begin
        state_d     = state_q;
        insn_d      = insn_q;
        pc_d        = pc_q;
        upd_en_d    = upd_en_q;
        upd_idx_d   = upd_idx_q;
        upd_data_d  = upd_data_q;
        ld_pend_d   = ld_pend_q;
        ld_idx_d    = ld_idx_q;
        req_d       = mem_req_q;
        we_d        = mem_we_q;
        size_d      = mem_size_q;
        addr_d      = mem_addr_q;
        wdata_d     = mem_wdata_q;
        wb_en_d     = 1'b0;
        wb_idx_d    = wb_idx_q;
        wb_data_d   = wb_data_q;
        pass_d      = 1'b0;
        pass_insn_d = pass_insn_q;
        done_d      = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (insn_valid) begin
                    insn_d = insn;
                    pc_d   = pc;
                    if (!dec_in.ok) begin
                        pass_d      = 1'b1;            // [RL18]
                        pass_insn_d = insn;
                    end else begin
                        ld_pend_d = 1'b0;
                        state_d   = hazard ? ST_STALL
                                           : ST_READ;  // [RL14]
                    end
                end
            end
            ST_STALL: state_d = ST_READ;
            ST_READ:  state_d = ST_EXEC;
            ST_EXEC: begin
                if (dec.imm || dec.rr) begin
                    wb_en_d   = 1'b1;
                    wb_idx_d  = dec.dst;
                    wb_data_d = dec.imm
                        ? {{24{insn_q[7]}}, insn_q[7:0]} // [RL3]
                        : rf.ra_data;                  // [RL16]
                    state_d   = ST_WB;
                end else begin
                    req_d   = 1'b1;
                    we_d    = dec.st;
                    size_d  = dec.sz;
                    wdata_d = dec.dat_c ? rf.rc_data : rf.ra_data;
                    if (dec.upd == UPD_PRE) begin
                        addr_d = rf.rb_data - step;    // [RL6]
                    end else begin
                        addr_d = base + ({24'h0, dec.disp}
                                         << dec.sz);   // [RL2]
                    end
                    upd_en_d   = dec.upd != UPD_NONE;
                    upd_idx_d  = (dec.upd == UPD_PRE) ? insn_q[11:8]
                                                      : insn_q[7:4];
                    upd_data_d = (dec.upd == UPD_PRE)
                        ? rf.rb_data - step
                        : rf.ra_data + step;           // [RL7]
                    state_d    = ST_MEM;
                end
            end
            ST_MEM: begin
                if (mem_ack) begin
                    req_d = 1'b0;
                    we_d  = 1'b0;
                    if (!mem_we_q) begin
                        wb_en_d   = 1'b1;
                        wb_idx_d  = dec.dst;
                        wb_data_d = sext(mem_rdata, dec.sz); // [RL5]
                        ld_pend_d = 1'b1;
                        ld_idx_d  = dec.dst;
                        state_d   = ST_WB;
                    end else if (upd_en_q) begin
                        wb_en_d   = 1'b1;
                        wb_idx_d  = upd_idx_q;
                        wb_data_d = upd_data_q;        // [RL6]
                        upd_en_d  = 1'b0;
                        state_d   = ST_WB;
                    end else begin
                        done_d  = 1'b1;                // [RL17]
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_WB: begin
                // Post-increment update is written after the load
                if (upd_en_q) begin
                    wb_en_d   = 1'b1;
                    wb_idx_d  = upd_idx_q;
                    wb_data_d = upd_data_q;            // [RL7]
                    upd_en_d  = 1'b0;
                end else begin
                    done_d  = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        ready_d = state_d == ST_IDLE;
    end

    // Registers only; every output is one of these flops
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q       <= ST_IDLE;
            insn_q        <= 16'h0;
            pc_q          <= 32'h0;
            upd_en_q      <= 1'b0;
            upd_idx_q     <= 4'h0;
            upd_data_q    <= 32'h0;
            ld_pend_q     <= 1'b0;
            ld_idx_q      <= 4'h0;
            insn_ready_q  <= 1'b0;
            mem_req_q     <= 1'b0;
            mem_we_q      <= 1'b0;
            mem_size_q    <= 2'h0;
            mem_addr_q    <= 32'h0;
            mem_wdata_q   <= 32'h0;
            wb_en_q       <= 1'b0;
            wb_idx_q      <= 4'h0;
            wb_data_q     <= 32'h0;
            pass_q        <= 1'b0;
            pass_insn_q   <= 16'h0;
            done_q        <= 1'b0;
            base_cycles_q <= 4'h0;
            priv_req_q    <= 1'b0;
            tbit_we_q     <= 1'b0;
        end else begin
            state_q       <= state_d;
            insn_q        <= insn_d;
            pc_q          <= pc_d;
            upd_en_q      <= upd_en_d;
            upd_idx_q     <= upd_idx_d;
            upd_data_q    <= upd_data_d;
            ld_pend_q     <= ld_pend_d;
            ld_idx_q      <= ld_idx_d;
            insn_ready_q  <= ready_d;
            mem_req_q     <= req_d;
            mem_we_q      <= we_d;
            mem_size_q    <= size_d;
            mem_addr_q    <= addr_d;
            mem_wdata_q   <= wdata_d;
            wb_en_q       <= wb_en_d;
            wb_idx_q      <= wb_idx_d;
            wb_data_q     <= wb_data_d;
            pass_q        <= pass_d;
            pass_insn_q   <= pass_insn_d;
            done_q        <= done_d;
            base_cycles_q <= `DTD_BASE_CYCLES;         // [RL13]
            priv_req_q    <= 1'b0;                     // [RL15]
            tbit_we_q     <= 1'b0;                     // [RL15]
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    field_sel_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL1]
        state_q == ST_EXEC && (dec.imm || dec.rr) |=>
        wb_en_q && wb_idx_q == $past(insn_q[11:8]))
        else $error("register field select wrong");
    imm_sext_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL3]
        state_q == ST_EXEC && dec.imm |=> wb_en_q &&
        wb_data_q == {{24{$past(insn_q[7])}}, $past(insn_q[7:0])})
        else $error("immediate not sign-extended");
    rr_copy_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL16]
        state_q == ST_EXEC && dec.rr |=> wb_data_q == $past(rf.ra_data))
        else $error("register move data wrong");
    pre_dec_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL6]
        state_q == ST_EXEC && dec.upd == UPD_PRE |=>
        mem_addr_q == $past(rf.rb_data) - $past(step) && mem_we_q)
        else $error("pre-decrement address wrong");
    disp_scale_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL2]
        state_q == ST_EXEC && (dec.ld || dec.st) && dec.upd != UPD_PRE
        |=> mem_addr_q ==
            $past(base) + ({24'h0, $past(dec.disp)} << $past(dec.sz)))
        else $error("displacement scaling wrong");
    no_flag_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL15]
        !priv_req_q && !tbit_we_q)
        else $error("privilege or flag touched");
    pass_nomem_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL18]
        state_q == ST_IDLE && insn_valid && !dec_in.ok |=>
        pass_q && !mem_req_q && state_q == ST_IDLE)
        else $error("foreign encoding not passed on");
    load_stall_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL14]
        state_q == ST_IDLE && insn_valid && dec_in.ok && hazard |=>
        state_q == ST_STALL ##1 state_q == ST_READ)
        else $error("load-use stall missing");
    min_cycle_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL13]
        state_q == ST_IDLE && insn_valid && dec_in.ok |=> !done_q [*2])
        else $error("instruction finished too soon");

endmodule : dtd_decode

// *** verification/dtd_mem_model.sv ***
`timescale 1ns/1ps

// ********************
// Data memory stand-in
// ********************
module dtd_mem_model (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [1:0]  lat,
    input  wire logic        mem_req_q,
    input  wire logic [31:0] mem_addr_q,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata
);
    logic [1:0] cnt_q;

    // Ack after lat waits; read bus toggles otherwise so stale data fails
    always @(posedge clock) begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (!rst_n) begin
            cnt_q     <= 2'h0;
            mem_rdata <= 32'h0;
        end else if (mem_req_q && !mem_ack) begin
            cnt_q <= cnt_q + 2'h1;
            if (cnt_q == lat) begin
                mem_ack   <= 1'b1;
                mem_rdata <= {2{mem_addr_q[15:0] ^ 16'h8181}};
                cnt_q     <= 2'h0;
            end
        end
    end
endmodule : dtd_mem_model

// *** verification/data_transfer_insn_decode_bench.sv ***
`timescale 1ns/1ps

`define DTD_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("Error %0t got %h exp %h", $time, g, e); end end

module data_transfer_insn_decode_bench;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        insn_valid = 1'b0;
    logic [15:0] insn = 16'h0;
    logic [31:0] pc = 32'h0;
    logic [1:0]  lat = 2'h0;
    logic        mem_ack, insn_ready_q, mem_req_q, mem_we_q, wb_en_q;
    logic        pass_q, done_q, priv_req_q, tbit_we_q;
    logic [1:0]  mem_size_q;
    logic [3:0]  wb_idx_q, base_cycles_q;
    logic [15:0] pass_insn_q;
    logic [31:0] mem_rdata, mem_addr_q, mem_wdata_q, wb_data_q;
    int          num_errors = 0;
    int          total_checks = 0;

    always #2 clock = ~clock;

    dtd_decode u_dtd_decode (.clock(clock), .rst_n(rst_n),
        .insn_valid(insn_valid), .insn(insn), .pc(pc),
        .insn_ready_q(insn_ready_q), .mem_req_q(mem_req_q),
        .mem_we_q(mem_we_q), .mem_size_q(mem_size_q),
        .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .wb_en_q(wb_en_q),
        .wb_idx_q(wb_idx_q), .wb_data_q(wb_data_q), .pass_q(pass_q),
        .pass_insn_q(pass_insn_q), .done_q(done_q),
        .base_cycles_q(base_cycles_q), .priv_req_q(priv_req_q),
        .tbit_we_q(tbit_we_q));

    dtd_mem_model u_dtd_mem_model (.clock(clock), .rst_n(rst_n),
        .lat(lat), .mem_req_q(mem_req_q), .mem_addr_q(mem_addr_q),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // ****************
    // Shared drivers
    // ****************
    task automatic close_out;
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // One cycle; a hang past the bound ends the run as a failure
    task automatic tick(inout int k);
        @(posedge clock);
        #1;
        k++;
        if (k > 40) begin
            num_errors++;
            close_out();
        end
    endtask : tick

    // mk is {write, size}, 3'h7 for no access; a second write-back is
    // the post-increment of the base
    task automatic op(input logic [15:0] ins, input logic [2:0] mk,
                      input logic [31:0] ma, md, input int n,
                      input logic [3:0] i1, input logic [31:0] d1,
                      input int cyc);
        int k;
        int w;
        k = 0;
        w = 0;
        insn       = ins;
        insn_valid = 1'b1;
        while (insn_ready_q !== 1'b1) tick(k);
        tick(k);
        insn_valid = 1'b0;
        k = 0;
        while (done_q !== 1'b1 && pass_q !== 1'b1) begin
            `DTD_CHK({priv_req_q, tbit_we_q}, 2'h0)
            if (mem_req_q === 1'b1) begin
                `DTD_CHK({mem_we_q, mem_size_q}, mk)
                `DTD_CHK(mem_addr_q, ma)
                if (mk[2]) `DTD_CHK(mem_wdata_q, md)
            end
            if (wb_en_q === 1'b1 && w == 0) begin
                `DTD_CHK({wb_idx_q, wb_data_q}, {i1, d1})
                if (cyc > 0) `DTD_CHK(k, cyc)
            end
            if (wb_en_q === 1'b1 && w == 1)
                `DTD_CHK({wb_idx_q, wb_data_q},
                         {ins[7:4], ma + (32'h1 << mk[1:0])})
            if (wb_en_q === 1'b1) w++;
            tick(k);
        end
        `DTD_CHK(w, n)
        `DTD_CHK(pass_q, (mk == 3'h7 && n == 0))
        if (pass_q === 1'b1) `DTD_CHK({pass_insn_q, mem_req_q}, {ins, 1'b0})
    endtask : op

    // ****************
    // Scenarios
    // ****************
    task automatic s_imm;
        op(16'hE1FF, 3'h7, 0, 0, 1, 4'h1, 32'hFFFFFFFF, 2);
        op(16'hE27F, 3'h7, 0, 0, 1, 4'h2, 32'h7F, 2);
        op(16'hE110, 3'h7, 0, 0, 1, 4'h1, 32'h10, 2);
        op(16'h6323, 3'h7, 0, 0, 1, 4'h3, 32'h7F, 0);
    endtask : s_imm

    // Load-use: the instruction after the load names the loaded register
    task automatic s_ind;
        op(16'h6410, 3'h0, 32'h10, 0, 1, 4'h4, 32'hFFFFFF91, 0);
        op(16'hE405, 3'h7, 0, 0, 1, 4'h4, 32'h5, 3);
        op(16'hE505, 3'h7, 0, 0, 1, 4'h5, 32'h5, 2);
        op(16'h6612, 3'h2, 32'h10, 0, 1, 4'h6, 32'h81918191, 0);
    endtask : s_ind

    task automatic s_incdec;
        lat = 2'h3;
        op(16'h6515, 3'h1, 32'h10, 0, 2, 4'h5, 32'hFFFF8191, 0);
        op(16'h2126, 3'h6, 32'h0E, 32'h7F, 1, 4'h1, 32'h0E, 0);
        op(16'h2124, 3'h4, 32'h0D, 32'h7F, 1, 4'h1, 32'h0D, 0);
        op(16'h2120, 3'h4, 32'h0D, 32'h7F, 0, 4'h0, 0, 0);
    endtask : s_incdec

    // Base register R1 holds 0D here, R0 still zero until 8414
    task automatic s_disp;
        lat = 2'h1;
        op(16'h1123, 3'h6, 32'h19, 32'h7F, 0, 4'h0, 0, 0);
        op(16'h8013, 3'h4, 32'h10, 32'h0, 0, 4'h0, 0, 0);
        op(16'h8113, 3'h5, 32'h13, 32'h0, 0, 4'h0, 0, 0);
        op(16'h8414, 3'h0, 32'h11, 0, 1, 4'h0, 32'hFFFFFF90, 0);
        op(16'h8512, 3'h1, 32'h11, 0, 1, 4'h0, 32'hFFFF8190, 0);
        op(16'h5212, 3'h2, 32'h15, 0, 1, 4'h2, 32'h81948194, 0);
        op(16'h0324, 3'h4, 32'hFFFF820F, 32'h81948194, 0, 4'h0, 0, 0);
    endtask : s_disp

    task automatic s_pc;
        pc = 32'h100;
        op(16'h9603, 3'h1, 32'h106, 0, 1, 4'h6, 32'hFFFF8087, 0);
        pc = 32'h200;
        op(16'hD703, 3'h2, 32'h20C, 0, 1, 4'h7, 32'h838D838D, 0);
        op(16'h3120, 3'h7, 0, 0, 0, 4'h0, 0, 0);
        op(16'h6328, 3'h7, 0, 0, 0, 4'h0, 0, 0);
    endtask : s_pc

    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        `DTD_CHK({base_cycles_q, insn_ready_q}, 5'h03)
        s_imm();
        s_ind();
        s_incdec();
        s_disp();
        s_pc();
        close_out();
    end
endmodule : data_transfer_insn_decode_bench
